/* rtl/vsx_params.svh */
/*
 * Constants of the virtual interrupt command executor: opcodes, field
 * positions inside the command packet, error codes and pointer sizes.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef VSX_PARAMS_SVH
`define VSX_PARAMS_SVH

// ------------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------------
`define VSX_OP_SOFT      8'h23
`define VSX_OP_VSYNC     8'h25

// ------------------------------------------------------------------
// Field positions (doubleword 0 and 1 of the packet)
// ------------------------------------------------------------------
`define VSX_OP_HI        7
`define VSX_OP_LO        0
`define VSX_E_BIT        8
`define VSX_C_BIT        9
`define VSX_G_BIT        10
`define VSX_N_BIT        11
`define VSX_PRI_HI       23
`define VSX_PRI_LO       20
`define VSX_INT_HI       35
`define VSX_INT_LO       32
`define VSX_VPE_HI       47
`define VSX_VPE_LO       32

// ------------------------------------------------------------------
// Widths, values and counts
// ------------------------------------------------------------------
`define VSX_VPE_W        16
`define VSX_INT_W        4
`define VSX_TGT_W        32
`define VSX_PTR_W        20
`define VSX_PRI_LOW_BITS 4'h0
`define VSX_CMD_BYTES    20'h00020
`define VSX_PTR_RST      20'h00000
`define VSX_ERR_NONE     2'h0
`define VSX_ERR_VPE_OOR  2'h1
`define VSX_ERR_UNMAPPED 2'h2

`endif

/* rtl/vsx_pkg.sv */
/*
 * Types of the virtual interrupt command executor.
 * Assumes vsx_params.svh is on the include path.
 */
`include "vsx_params.svh"

package vsx_pkg;

    typedef enum logic [2:0] {
        VSX_IDLE  = 3'b000,
        VSX_LOOK  = 3'b001,
        VSX_ISSUE = 3'b010,
        VSX_SYNC  = 3'b011,
        VSX_DONE  = 3'b100
    } vsx_state_t;

    typedef struct packed {
        vsx_state_t             st;
        logic                   cmd_ready;
        logic                   is_sync;
        logic [`VSX_VPE_W-1:0]  vpe;
        logic [`VSX_INT_W-1:0]  intid;
        logic                   en;
        logic                   grp;
        logic                   nmi;
        logic                   clr;
        logic [7:0]             pri;
        logic                   vte_req;
        logic                   rd_req;
        logic [`VSX_TGT_W-1:0]  target;
        logic                   sync_req;
        logic                   xlate_hold;
        logic                   err;
        logic [1:0]             err_code;
        logic                   adv;
        logic                   done;
    } vsx_exec_t;

    typedef struct packed {
        logic [`VSX_PTR_W-1:0]  ptr;
    } vsx_ptr_t;

endpackage : vsx_pkg

/* rtl/vsx_decode.sv */
/*
 * Field decoder for the two virtual commands; purely combinational.
 * Assumes doublewords 0 and 1 of a packet; the rest is reserved.
 */
`timescale 1ns/1ns
`include "vsx_params.svh"

module vsx_decode
    import vsx_pkg::*;
(
    input  wire logic [63:0]            dw0,
    input  wire logic [63:0]            dw1,
    input  wire logic                   nmi_supported,
    input  wire logic                   grp0_nmi_keep,
    output logic                        is_soft,
    output logic                        is_vsync,
    output logic [`VSX_VPE_W-1:0]       vpe,
    output logic [`VSX_INT_W-1:0]       intid,
    output logic                        en,
    output logic                        grp,
    output logic                        clr,
    output logic [7:0]                  pri,
    output logic                        nmi
);

    logic n_raw;

    always_comb
    begin
        is_soft  = (dw0[`VSX_OP_HI:`VSX_OP_LO] == `VSX_OP_SOFT);   // [RQ1]
        is_vsync = (dw0[`VSX_OP_HI:`VSX_OP_LO] == `VSX_OP_VSYNC);  // [RQ13]
        // Only named fields are read; reserved bits never matter [RQ24] [RQ17]
        vpe      = dw1[`VSX_VPE_HI:`VSX_VPE_LO];
        intid    = dw0[`VSX_INT_HI:`VSX_INT_LO];
        clr      = dw0[`VSX_C_BIT];
        // Configuration fields dropped while clearing [RQ3]
        en       = dw0[`VSX_E_BIT] & ~clr;
        grp      = dw0[`VSX_G_BIT] & ~clr;
        pri      = clr ? 8'h00 : {dw0[`VSX_PRI_HI:`VSX_PRI_LO], `VSX_PRI_LOW_BITS}; // [RQ2]
        n_raw    = dw0[`VSX_N_BIT] & nmi_supported & ~clr;          // [RQ4]
        // Group 0 with the flag: keep it or drop it, per strap [RQ7]
        nmi      = n_raw & (grp | grp0_nmi_keep);
    end

endmodule : vsx_decode

/* rtl/vsx_rdptr.sv */
/*
 * Command read pointer: advances one packet per completed command and
 * wraps to the queue start. Assumes queue_bytes is a multiple of 32.
 */
`timescale 1ns/1ns
`include "vsx_params.svh"

module vsx_rdptr
    import vsx_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   adv,
    input  wire logic [`VSX_PTR_W-1:0]  queue_bytes,
    output logic [`VSX_PTR_W-1:0]       rd_ptr
);

    vsx_ptr_t s_ff;
    vsx_ptr_t nxt_s;
    logic [`VSX_PTR_W:0] sum;

    always_comb
    begin
        nxt_s = s_ff;
        sum   = {1'b0, s_ff.ptr} + {1'b0, `VSX_CMD_BYTES};
        if (adv)
        begin
            // Wrap when reaching the queue end [RQ23]
            if (sum >= {1'b0, queue_bytes})
                nxt_s.ptr = `VSX_PTR_RST;
            else
                nxt_s.ptr = sum[`VSX_PTR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            s_ff <= '{ptr: `VSX_PTR_RST};
        else
            s_ff <= nxt_s;
    end

    assign rd_ptr = s_ff.ptr;

    property p_ptr_wrap;
        @(posedge clk_sys) disable iff (!rstn)
        adv |=> (rd_ptr == ((({1'b0, $past(rd_ptr)} + {1'b0, `VSX_CMD_BYTES})
                 >= {1'b0, $past(queue_bytes)}) ? `VSX_PTR_RST
                 : $past(rd_ptr) + `VSX_CMD_BYTES));
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("read pointer step wrong"); // [RQ23]

    property p_ptr_still;
        @(posedge clk_sys) disable iff (!rstn)
        !adv |=> $stable(rd_ptr);
    endproperty
    a_ptr_still: assert property (p_ptr_still) else $error("read pointer moved"); // [RQ23]

endmodule : vsx_rdptr

/* rtl/vsx_exec.sv */
/*
 * Executor for the virtual software interrupt configuration command and
 * the virtual PE synchronisation command, one command at a time.
 * Assumes a same-clock command fetcher, vPE table lookup port,
 * redistributor request port and completion tracker on the far side.
 */
//
// Summary of operation
// [RQ1] Opcode 0x23 in low byte of doubleword 0 is the soft interrupt command.
// [RQ2] Priority carries bits 7:4; bits 3:0 are forced to zero.
// [RQ3] Enable and group come from the command, dropped when clearing pending.
// [RQ4] Non-maskable flag honoured only where supported, else ignored.
// [RQ5] Without clear, configuration is written and pending state untouched.
// [RQ6] With clear, only pending state is cleared, configuration kept.
// [RQ7] Group 0 with non-maskable flag: flag kept or dropped per strap.
// [RQ8] Software leaves priority zero when non-maskable flag set.
// [RQ9] Soft interrupt command with vPE above configured range is an error.
// [RQ10] vPE mapped nowhere: command completes with only a pointer advance.
// [RQ11] vPE mapped elsewhere only: update or no effect, per strap.
// [RQ12] Soft interrupt effects guaranteed visible only after a later sync.
// [RQ13] Opcode 0x25 is sync; nothing later runs until vPE work observed.
// [RQ14] After sync, all earlier effects govern later doorbell writes.
// [RQ15] Sync looks up target, waits for all redistributors, then advances.
// [RQ16] Sync with unmapped or out-of-range vPE is an error.
// [RQ17] Packet is 32 bytes, four doublewords; fields placed by index.
// [RQ18] Each command behaves as atomic; later translations see full effect.
// [RQ19] Requests to one redistributor go out in order, writes not awaited.
// [RQ20] Table writes not awaited but ordered before later operations.
// [RQ21] Pending moves clear at source and set at destination atomically.
// [RQ22] Cache invalidation uses the vPE entry; invalid entry is failure.
// [RQ23] Each completed command advances the read pointer with wrap.
// [RQ24] Reserved fields of both packets are ignored.
//
`timescale 1ns/1ns
`include "vsx_params.svh"

module vsx_exec
    import vsx_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   cmd_valid,
    input  wire logic [63:0]            cmd_dw0,
    input  wire logic [63:0]            cmd_dw1,
    output logic                        cmd_ready,
    input  wire logic [`VSX_VPE_W-1:0]  max_vpe,
    input  wire logic                   nmi_supported,
    input  wire logic                   grp0_nmi_keep,
    input  wire logic                   remote_update_en,
    input  wire logic [`VSX_PTR_W-1:0]  queue_bytes,
    output logic                        vte_req,
    output logic [`VSX_VPE_W-1:0]       vte_vpe,
    input  wire logic                   vte_ack,
    input  wire logic                   vte_local_valid,
    input  wire logic                   vte_remote_valid,
    input  wire logic [`VSX_TGT_W-1:0]  vte_target,
    output logic                        rd_req,
    output logic                        rd_clr,
    output logic [`VSX_TGT_W-1:0]       rd_target,
    output logic [`VSX_VPE_W-1:0]       rd_vpe,
    output logic [`VSX_INT_W-1:0]       rd_intid,
    output logic                        rd_en,
    output logic                        rd_grp,
    output logic [7:0]                  rd_pri,
    output logic                        rd_nmi,
    input  wire logic                   rd_ack,
    output logic                        sync_req,
    output logic [`VSX_TGT_W-1:0]       sync_target,
    input  wire logic                   sync_done,
    input  wire logic                   mem_idle,
    output logic                        xlate_hold,
    output logic                        cmd_err,
    output logic [1:0]                  cmd_err_code,
    output logic                        cmd_done,
    output logic [`VSX_PTR_W-1:0]       rd_ptr
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic                   d_soft;
    logic                   d_vsync;
    logic [`VSX_VPE_W-1:0]  d_vpe;
    logic [`VSX_INT_W-1:0]  d_intid;
    logic                   d_en;
    logic                   d_grp;
    logic                   d_clr;
    logic [7:0]             d_pri;
    logic                   d_nmi;
    logic                   accept;
    logic                   d_oor;

    vsx_decode u_decode (
        .dw0           (cmd_dw0),
        .dw1           (cmd_dw1),
        .nmi_supported (nmi_supported),
        .grp0_nmi_keep (grp0_nmi_keep),
        .is_soft       (d_soft),
        .is_vsync      (d_vsync),
        .vpe           (d_vpe),
        .intid         (d_intid),
        .en            (d_en),
        .grp           (d_grp),
        .clr           (d_clr),
        .pri           (d_pri),
        .nmi           (d_nmi)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    vsx_exec_t s_ff;
    vsx_exec_t nxt_s;

    assign accept = cmd_valid & s_ff.cmd_ready;
    assign d_oor  = (d_vpe > max_vpe);

    always_comb
    begin
        nxt_s      = s_ff;
        nxt_s.err  = 1'b0;
        nxt_s.adv  = 1'b0;
        nxt_s.done = 1'b0;
        unique case (s_ff.st)
            VSX_IDLE:
            begin
                if (accept)
                begin
                    nxt_s.cmd_ready  = 1'b0;
                    // Translations held off while a command runs [RQ18] [RQ14]
                    nxt_s.xlate_hold = 1'b1;
                    nxt_s.is_sync    = d_vsync;
                    nxt_s.vpe        = d_vpe;
                    nxt_s.intid      = d_intid;
                    nxt_s.en         = d_en;
                    nxt_s.grp        = d_grp;
                    nxt_s.clr        = d_clr;
                    nxt_s.pri        = d_pri;
                    nxt_s.nmi        = d_nmi;
                    if ((d_soft | d_vsync) && d_oor)
                    begin
                        // Out-of-range vPE [RQ9] [RQ16]
                        nxt_s.st       = VSX_DONE;
                        nxt_s.err      = 1'b1;
                        nxt_s.err_code = `VSX_ERR_VPE_OOR;
                        nxt_s.adv      = 1'b1;
                        nxt_s.done     = 1'b1;
                    end
                    else if (d_soft | d_vsync)
                    begin
                        nxt_s.st      = VSX_LOOK;
                        nxt_s.vte_req = 1'b1;
                    end
                    else
                    begin
                        // Other opcodes belong elsewhere; retire untouched
                        nxt_s.st   = VSX_DONE;
                        nxt_s.adv  = 1'b1;
                        nxt_s.done = 1'b1;
                    end
                end
            end
            VSX_LOOK:
            begin
                if (vte_ack)
                begin
                    nxt_s.vte_req = 1'b0;
                    nxt_s.target  = vte_target;                     // [RQ15]
                    if (s_ff.is_sync)
                    begin
                        if (vte_local_valid)
                        begin
                            nxt_s.st       = VSX_SYNC;
                            nxt_s.sync_req = 1'b1;
                        end
                        else
                        begin
                            // Invalid vPE entry is a failure [RQ16] [RQ22]
                            nxt_s.st       = VSX_DONE;
                            nxt_s.err      = 1'b1;
                            nxt_s.err_code = `VSX_ERR_UNMAPPED;
                            nxt_s.adv      = 1'b1;
                            nxt_s.done     = 1'b1;
                        end
                    end
                    else if (vte_local_valid | (vte_remote_valid & remote_update_en)) // [RQ11]
                    begin
                        // Config write or pending clear, never both [RQ5] [RQ6]
                        nxt_s.st     = VSX_ISSUE;
                        nxt_s.rd_req = 1'b1;
                    end
                    else
                    begin
                        // No effect beyond the pointer [RQ10]
                        nxt_s.st   = VSX_DONE;
                        nxt_s.adv  = 1'b1;
                        nxt_s.done = 1'b1;
                    end
                end
            end
            VSX_ISSUE:
            begin
                // Single ordered request; completion is not awaited [RQ19] [RQ21] [RQ12]
                if (rd_ack)
                begin
                    nxt_s.rd_req = 1'b0;
                    nxt_s.st     = VSX_DONE;
                    nxt_s.adv    = 1'b1;
                    nxt_s.done   = 1'b1;
                end
            end
            VSX_SYNC:
            begin
                // Wait for redistributors and table writes [RQ13] [RQ15] [RQ20]
                if (sync_done && mem_idle)
                begin
                    nxt_s.sync_req = 1'b0;
                    nxt_s.st       = VSX_DONE;
                    nxt_s.adv      = 1'b1;
                    nxt_s.done     = 1'b1;
                end
            end
            VSX_DONE:
            begin
                nxt_s.st         = VSX_IDLE;
                nxt_s.cmd_ready  = 1'b1;
                nxt_s.xlate_hold = 1'b0;
                nxt_s.err_code   = `VSX_ERR_NONE;
            end
            default:
            begin
                nxt_s = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_ff           <= '0;
            s_ff.cmd_ready <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    // ------------------------------------------------------------------
    // Read pointer
    // ------------------------------------------------------------------
    vsx_rdptr u_rdptr (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .adv         (s_ff.adv),
        .queue_bytes (queue_bytes),
        .rd_ptr      (rd_ptr)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cmd_ready    = s_ff.cmd_ready;
    assign vte_req      = s_ff.vte_req;
    assign vte_vpe      = s_ff.vpe;
    assign rd_req       = s_ff.rd_req;
    assign rd_clr       = s_ff.clr;
    assign rd_target    = s_ff.target;
    assign rd_vpe       = s_ff.vpe;
    assign rd_intid     = s_ff.intid;
    assign rd_en        = s_ff.en;
    assign rd_grp       = s_ff.grp;
    assign rd_pri       = s_ff.pri;
    assign rd_nmi       = s_ff.nmi;
    assign sync_req     = s_ff.sync_req;
    assign sync_target  = s_ff.target;
    assign xlate_hold   = s_ff.xlate_hold;
    assign cmd_err      = s_ff.err;
    assign cmd_err_code = s_ff.err_code;
    assign cmd_done     = s_ff.done;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_soft_lookup;
        @(posedge clk_sys) disable iff (!rstn)
        accept && cmd_dw0[7:0] == 8'h23 && !d_oor |=> vte_req && !s_ff.is_sync;
    endproperty
    a_soft_lookup: assert property (p_soft_lookup) else $error("lookup missing"); // [RQ1]

    property p_pri_low;
        @(posedge clk_sys) disable iff (!rstn)
        rd_req |-> rd_pri[3:0] == 4'h0;
    endproperty
    a_pri_low: assert property (p_pri_low) else $error("low priority bits set"); // [RQ2]

    property p_clr_ignores;
        @(posedge clk_sys) disable iff (!rstn)
        rd_req && rd_clr |-> !rd_en && !rd_grp && !rd_nmi && rd_pri == 8'h00;
    endproperty
    a_clr_ignores: assert property (p_clr_ignores) else $error("config on clear"); // [RQ3]

    property p_nmi_gate;
        @(posedge clk_sys) disable iff (!rstn)
        accept && !nmi_supported |=> !s_ff.nmi;
    endproperty
    a_nmi_gate: assert property (p_nmi_gate) else $error("nmi without support"); // [RQ4]

    property p_oor_err;
        @(posedge clk_sys) disable iff (!rstn)
        accept && (d_soft || d_vsync) && d_oor
            |=> cmd_err && cmd_err_code == 2'h1 && cmd_done ##1 cmd_ready;
    endproperty
    a_oor_err: assert property (p_oor_err) else $error("range error missed"); // [RQ9]

    property p_unmapped_noeffect;
        @(posedge clk_sys) disable iff (!rstn)
        s_ff.st == VSX_LOOK && vte_ack && !vte_local_valid && !vte_remote_valid
            && !s_ff.is_sync |=> cmd_done && !cmd_err && !rd_req;
    endproperty
    a_unmapped_noeffect: assert property (p_unmapped_noeffect) else $error("unmapped"); // [RQ10]

    property p_sync_blocks;
        @(posedge clk_sys) disable iff (!rstn)
        sync_req && !(sync_done && mem_idle) |=> sync_req && !cmd_ready && xlate_hold;
    endproperty
    a_sync_blocks: assert property (p_sync_blocks) else $error("sync released early"); // [RQ13]

    property p_sync_unmapped;
        @(posedge clk_sys) disable iff (!rstn)
        s_ff.st == VSX_LOOK && vte_ack && !vte_local_valid && s_ff.is_sync
            |=> cmd_err && cmd_err_code == 2'h2;
    endproperty
    a_sync_unmapped: assert property (p_sync_unmapped) else $error("sync error missed"); // [RQ16]

    property p_sync_target;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(sync_req) |-> sync_target == $past(vte_target);
    endproperty
    a_sync_target: assert property (p_sync_target) else $error("sync target wrong"); // [RQ15]

    property p_done_ready;
        @(posedge clk_sys) disable iff (!rstn)
        cmd_done |-> !cmd_ready ##1 cmd_ready && !xlate_hold;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("ready not restored"); // [RQ18]

    c_soft_cfg: cover property (@(posedge clk_sys) disable iff (!rstn)
        rd_req && rd_ack && !rd_clr);
    c_soft_clr: cover property (@(posedge clk_sys) disable iff (!rstn)
        rd_req && rd_ack && rd_clr);
    c_sync_ok: cover property (@(posedge clk_sys) disable iff (!rstn)
        sync_req ##1 sync_req ##1 !sync_req);
    c_err: cover property (@(posedge clk_sys) disable iff (!rstn) cmd_err);

endmodule : vsx_exec

/* sim/vsx_far.sv */
/*
 * Far-side model: vPE table lookup, redistributor port, completion tracker.
 * Assumes the executor's clock; slow stretches every answer and drain.
 */
`timescale 1ns/1ns

module vsx_far
    import vsx_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        vte_req,
    input  wire logic [15:0] vte_vpe,
    output logic             vte_ack,
    output logic             vte_local_valid,
    output logic             vte_remote_valid,
    output logic [31:0]      vte_target,
    input  wire logic        rd_req,
    output logic             rd_ack,
    input  wire logic        sync_req,
    output logic             sync_done,
    output logic             mem_idle
);
    logic [2:0] cnt_ff;
    logic       tog_ff;
    wire        go = cnt_ff == (slow ? 3'h5 : 3'h1);

    // Entry fields carry junk outside the ack cycle
    assign vte_local_valid  = vte_ack ? vte_vpe == 16'h0001 : tog_ff;
    assign vte_remote_valid = vte_ack ? vte_vpe == 16'h0002 : ~tog_ff;
    assign vte_target       = vte_ack ? {16'h00a5, vte_vpe} : {32{tog_ff}};
    assign mem_idle         = slow ? tog_ff : 1'h1;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff    <= 3'h0;
            tog_ff    <= 1'h0;
            vte_ack   <= 1'h0;
            rd_ack    <= 1'h0;
            sync_done <= 1'h0;
        end
        else
        begin
            tog_ff    <= ~tog_ff;
            cnt_ff    <= (vte_req || rd_req || sync_req) && !go ? cnt_ff + 3'h1 : 3'h0;
            vte_ack   <= vte_req && go && !vte_ack;
            rd_ack    <= rd_req && go && !rd_ack;
            // Held until taken together with the drain flag
            sync_done <= sync_req && (go || sync_done) && !(sync_done && mem_idle);
        end
    end
endmodule : vsx_far

/* sim/vsx_exec_tb.sv */
/*
 * Self-checking bench for vsx_exec against the far-side model.
 * Assumes vsx_params.svh on the include path and vsx_pkg compiled first.
 */
`timescale 1ns/1ns

module vsx_exec_tb
    import vsx_pkg::*;
;
    logic clk_sys, rstn, cmd_valid, cmd_ready, nmi_supported, grp0_nmi_keep, remote_update_en;
    logic slow, vte_req, vte_ack, vte_local_valid, vte_remote_valid, rd_req, rd_clr, rd_en;
    logic rd_grp, rd_nmi, rd_ack, sync_req, sync_done, mem_idle, xlate_hold, cmd_err, cmd_done;
    logic [63:0] cmd_dw0, cmd_dw1;
    logic [31:0] vte_target, rd_target, sync_target;
    logic [15:0] max_vpe, vte_vpe, rd_vpe;
    logic [19:0] queue_bytes, rd_ptr;
    logic [7:0]  rd_pri;
    logic [3:0]  rd_intid;
    logic [1:0]  cmd_err_code;
    logic [63:0] cap;
    logic [32:0] cap_s;
    logic [2:0]  cap_e;
    int          n_wr, n_sync, n_done, n_errors, check_count, exp_ptr;

    vsx_exec uut (.clk_sys, .rstn, .cmd_valid, .cmd_dw0, .cmd_dw1, .cmd_ready, .max_vpe,
        .nmi_supported, .grp0_nmi_keep, .remote_update_en, .queue_bytes, .vte_req, .vte_vpe,
        .vte_ack, .vte_local_valid, .vte_remote_valid, .vte_target, .rd_req, .rd_clr,
        .rd_target, .rd_vpe, .rd_intid, .rd_en, .rd_grp, .rd_pri, .rd_nmi, .rd_ack, .sync_req,
        .sync_target, .sync_done, .mem_idle, .xlate_hold, .cmd_err, .cmd_err_code, .cmd_done,
        .rd_ptr);
    vsx_far far (.clk_sys, .rstn, .slow, .vte_req, .vte_vpe, .vte_ack, .vte_local_valid,
        .vte_remote_valid, .vte_target, .rd_req, .rd_ack, .sync_req, .sync_done, .mem_idle);

    initial
    begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Handshake capture at the sampling edge
    always @(posedge clk_sys)
    begin
        if (rd_req && rd_ack)
        begin
            n_wr++;
            cap = {rd_clr, rd_en, rd_grp, rd_nmi, rd_pri, rd_intid, rd_target, rd_vpe};
        end
        if (sync_req && sync_done && mem_idle)
        begin
            n_sync++;
            cap_s = {xlate_hold, sync_target};
        end
        if (cmd_done)
        begin
            n_done++;
            cap_e = {cmd_err, cmd_err_code};
        end
    end

    task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic run(input logic [63:0] d0, input logic [63:0] d1, input logic [2:0] ee);
        int i;
        n_wr = 0;
        n_sync = 0;
        n_done = 0;
        cap = 64'h0;
        cap_s = 33'h0;
        cap_e = 3'h7;
        cmd_dw0 = d0;
        cmd_dw1 = d1;
        cmd_valid = 1'h1;
        i = 0;
        do @(posedge clk_sys); while (cmd_ready !== 1'h1 && ++i < 50);
        @(negedge clk_sys);
        cmd_valid = 1'h0;
        i = 0;
        while (n_done == 0 && i < 200)
        begin
            @(negedge clk_sys);
            i++;
        end
        @(negedge clk_sys);
        exp_ptr = exp_ptr + 32 >= queue_bytes ? 0 : exp_ptr + 32;
        chk("err", ee, cap_e);
        chk("ptr", exp_ptr, rd_ptr);
        $display("test op %h done", d0[7:0]);
    endtask : run

    task automatic sg(input logic [3:0] f, input logic [3:0] pri, input logic [15:0] vpe,
                      input logic [15:0] ex, input logic [2:0] ee);
        run({28'habcdef1, 4'h5, 8'h5a, pri, 8'hc3, f, 8'h23}, {16'hbeef, vpe, 32'h12345678}, ee);
        chk("rd", ex === 16'h0 ? 68'h0 : {4'h1, ex, 16'h00a5, vpe, vpe},
            {n_wr[3:0], cap});
    endtask : sg

    task automatic sy(input logic [15:0] vpe, input logic [2:0] ee, input logic ok);
        run(64'h0123456789abcd25, {16'hbeef, vpe, 32'h12345678}, ee);
        chk("sync", ok ? {8'h01, 1'h1, 16'h00a5, vpe} : 41'h0,
            {n_wr[3:0], n_sync[3:0], cap_s});
    endtask : sy

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        {rstn, cmd_valid, grp0_nmi_keep, slow} = 4'h0;
        {nmi_supported, remote_update_en} = 2'h3;
        {cmd_dw0, cmd_dw1} = 128'h0;
        max_vpe = 16'h0004;
        queue_bytes = 20'h00080;
        {exp_ptr, n_errors, check_count} = 0;
        repeat (4) @(negedge clk_sys);
        chk("rst", {1'h1, 20'h0}, {cmd_ready, rd_ptr});
        rstn = 1'h1;
        sg(4'h5, 4'ha, 16'h1, 16'h6a05, 3'h0);
        sg(4'hf, 4'hf, 16'h1, 16'h8005, 3'h0);
        sg(4'h9, 4'h0, 16'h1, 16'h4005, 3'h0);
        sg(4'hc, 4'h0, 16'h1, 16'h3005, 3'h0);
        grp0_nmi_keep = 1'h1;
        slow = 1'h1;
        sg(4'h9, 4'h0, 16'h1, 16'h5005, 3'h0);
        nmi_supported = 1'h0;
        sg(4'hd, 4'h0, 16'h1, 16'h6005, 3'h0);
        sg(4'h5, 4'h3, 16'h5, 16'h0, 3'h5);
        sg(4'h5, 4'h3, 16'h4, 16'h0, 3'h0);
        sg(4'h5, 4'h3, 16'h2, 16'h6305, 3'h0);
        remote_update_en = 1'h0;
        sg(4'h5, 4'h3, 16'h2, 16'h0, 3'h0);
        sy(16'h1, 3'h0, 1'h1);
        sy(16'h3, 3'h6, 1'h0);
        sy(16'h5, 3'h5, 1'h0);
        run(64'hffffffffffffff24, 64'h0, 3'h0);
        results();
    end

    initial
    begin
        #100000;
        n_errors++;
        results();
    end
endmodule : vsx_exec_tb
